//--- logic/asm_pkg.sv
// Shared constants, types and helpers for the audio sample mover.
// Assumes a single core clock; ring indices stay below the ring size.
`default_nettype none
package asm_pkg;
   localparam int unsigned SMP_W = 16;
   localparam int unsigned IDX_W = 9;
   localparam int unsigned ADR_W = 16;
   localparam int unsigned BUF_W = 32;
   localparam int unsigned BUF_DEPTH = 16;
   localparam logic [IDX_W-1:0] RING_WORDS = 9'h180;
   localparam logic [IDX_W-1:0] HALF_WORDS = 9'h0C0;
   localparam logic [ADR_W-1:0] IN_RING_BASE = 16'h1800;
   localparam logic [ADR_W-1:0] OUT_RING_BASE = 16'h1800;
   localparam logic [IDX_W-1:0] BLOCK_LEN = 9'h020;
   localparam logic [7:0] CONV_DIV = 8'h40;
   localparam logic [SMP_W-1:0] MUTE_LEVEL = 16'h0000;

   typedef enum logic [1:0] {
      MODE_MONO   = 2'b00,
      MODE_SIMPLE = 2'b01,
      MODE_MIXED  = 2'b10,
      MODE_FULL   = 2'b11
   } asm_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WR_A = 3'b001,
      ST_WR_B = 3'b010,
      ST_RD_A = 3'b011,
      ST_RD_B = 3'b100
   } asm_state_t;

   // Adds two indices modulo span; both must already be below span.
   function automatic logic [IDX_W-1:0] ring_add(
      input logic [IDX_W-1:0] p,
      input logic [IDX_W-1:0] n,
      input logic [IDX_W-1:0] span);
      logic [IDX_W:0] s;
      s = {1'b0, p} + {1'b0, n};
      if (s >= {1'b0, span}) begin
         s = s - {1'b0, span};
      end
      return s[IDX_W-1:0];
   endfunction

   function automatic logic [ADR_W-1:0] ring_abs(
      input logic [ADR_W-1:0] base,
      input logic [IDX_W-1:0] idx);
      return base + {{(ADR_W-IDX_W){1'b0}}, idx};
   endfunction
endpackage
`default_nettype wire

//--- logic/asm_stream_if.sv
// Valid/ready word stream between the mover's own modules.
// Assumes source and sink share one clock.
`timescale 1ns/1ps
`default_nettype none
interface asm_stream_if #(parameter int unsigned W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- logic/asm_sample_fifo.sv
// Synchronous FIFO buffering captured sample frames.
// Assumes one clock and a synchronous-released active-low reset.
`timescale 1ns/1ps
`default_nettype none
module asm_sample_fifo import asm_pkg::*; #(
   parameter int unsigned W     = BUF_W,
   parameter int unsigned DEPTH = BUF_DEPTH
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   asm_stream_if.snk   wr,
   asm_stream_if.src   rd
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;
   logic         full;
   logic         empty;

   assign empty    = (wp_r == rp_r);
   assign full     = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = mem[rp_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (wr.valid && !full) begin
         mem[wp_r[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
      end else if (wr.valid && !full) begin
         wp_r <= wp_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rp_r <= '0;
      end else if (rd.ready && !empty) begin
         rp_r <= rp_r + 1'b1;
      end
   end
endmodule // asm_sample_fifo
`default_nettype wire

//--- logic/asm_view_map.sv
// Fixed-anchor view: maps an offset from the newest block to a RAM address.
// Assumes anchor and offset are below span; answer is one cycle late.
`timescale 1ns/1ps
`default_nettype none
module asm_view_map import asm_pkg::*; (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [ADR_W-1:0] base,
   input  wire logic [IDX_W-1:0] anchor,
   input  wire logic [IDX_W-1:0] span,
   input  wire logic [IDX_W-1:0] ofs,
   output logic      [ADR_W-1:0] addr_r
);
   logic [IDX_W-1:0] ofs_lim;

   // Offsets past the ring fold back once, so the address stays in it for offsets below twice the span.
   assign ofs_lim = (ofs >= span) ? ofs - span : ofs;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= 16'h0000;
      end else begin
         addr_r <= ring_abs(base, ring_add(anchor, ofs_lim, span));
      end
   end
endmodule // asm_view_map
`default_nettype wire

//--- logic/asm_mover.sv
// Audio sample mover: converter samples to RAM rings and back out.
// Assumes the shared RAM answers with mem_gnt, read data valid with it,
// and converter data stays stable for a whole sample period.
//
// Operation
// - Move input samples in, output samples out.
// - Rings live in RAM shared with core.
// - Normal view newest block moves forward.
// - Fixed-anchor view keeps newest block still.
// - Four channel layouts steer ring placement.
// - Mono layout stores samples consecutively.
// - Simple stereo: interleave in, lower out.
// - Mixed: input halves, output lower half.
// - Full stereo interleaves both directions.
// - Low battery mutes the output automatically.
// - Input ring kept filled, output ring drained, without software help.
// - Sample rate comes from converter clock.
`timescale 1ns/1ps
`default_nettype none
module asm_mover import asm_pkg::*; (
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             conv_clk,
   input  wire logic             low_batt,
   input  wire logic [1:0]       audio_mode,
   input  wire logic [SMP_W-1:0] adc_ch0,
   input  wire logic [SMP_W-1:0] adc_ch1,
   output logic      [SMP_W-1:0] dac_ch0_r,
   output logic      [SMP_W-1:0] dac_ch1_r,
   output logic                  mute_r,
   output logic                  mem_req,
   output logic                  mem_we_r,
   output logic                  mem_bank_r,
   output logic      [ADR_W-1:0] mem_addr_r,
   output logic      [SMP_W-1:0] mem_wdata_r,
   input  wire logic             mem_gnt,
   input  wire logic [SMP_W-1:0] mem_rdata,
   input  wire logic [IDX_W-1:0] smart_in_ofs,
   output logic      [ADR_W-1:0] smart_in_addr_r,
   input  wire logic [IDX_W-1:0] smart_out_ofs,
   output logic      [ADR_W-1:0] smart_out_addr_r,
   output logic      [ADR_W-1:0] in_newest_addr_r,
   output logic                  blk_full_pulse_r,
   input  wire logic             overrun_clr,
   output logic                  overrun_r
);
   logic [1:0]       rst_sync_r;
   logic             rst_n;
   logic [2:0]       conv_sync_r;
   logic [2:0]       batt_sync_r;
   logic             conv_lvl_r;
   logic             conv_prev_r;
   logic [7:0]       div_cnt_r;
   logic             tick_r;
   logic             cap_valid_r;
   logic [BUF_W-1:0] cap_data_r;
   asm_state_t       state_r;
   asm_mode_t        mode_r;
   logic [BUF_W-1:0] frame_r;
   logic [IDX_W-1:0] in_wp_r;
   logic [IDX_W-1:0] in_blk_start_r;
   logic [IDX_W-1:0] in_newest_r;
   logic [IDX_W-1:0] in_blk_cnt_r;
   logic [IDX_W-1:0] out_rp_r;
   logic [IDX_W-1:0] out_blk_start_r;
   logic [IDX_W-1:0] out_blk_cnt_r;
   logic             fetch_pend_r;
   logic [SMP_W-1:0] next_ch0_r;
   logic [SMP_W-1:0] next_ch1_r;
   logic             in_two;
   logic             in_done;
   logic             out_done;
   logic [IDX_W-1:0] in_span;
   logic [IDX_W-1:0] in_step;
   logic [IDX_W-1:0] out_span;
   logic [IDX_W-1:0] out_step;
   logic [IDX_W-1:0] in_idx_b;

   asm_stream_if #(.W(BUF_W)) cap_s ();
   asm_stream_if #(.W(BUF_W)) eng_s ();

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_sync_r <= 3'b000;
         batt_sync_r <= 3'b000;
      end else begin
         conv_sync_r <= {conv_sync_r[1:0], conv_clk};
         batt_sync_r <= {batt_sync_r[1:0], low_batt};
      end
   end

   // A pin level counts only once the last two stages agree.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_lvl_r  <= 1'b0;
         conv_prev_r <= 1'b0;
      end else begin
         if (conv_sync_r[1] == conv_sync_r[2]) begin
            conv_lvl_r <= conv_sync_r[2];
         end
         conv_prev_r <= conv_lvl_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 8'h00;
         tick_r    <= 1'b0;
      end else begin
         tick_r <= 1'b0;
         if (conv_lvl_r && !conv_prev_r) begin
            if (div_cnt_r == CONV_DIV - 8'h01) begin
               div_cnt_r <= 8'h00;
               tick_r    <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mute_r <= 1'b0;
      end else if (batt_sync_r[1] == batt_sync_r[2]) begin
         mute_r <= batt_sync_r[2];
      end
   end

   // capture held until the buffer accepts it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_valid_r <= 1'b0;
         cap_data_r  <= 32'h0000_0000;
      end else if (tick_r) begin
         cap_valid_r <= 1'b1;
         cap_data_r  <= {adc_ch1, adc_ch0};
      end else if (cap_s.ready) begin
         cap_valid_r <= 1'b0;
      end
   end
   assign cap_s.valid = cap_valid_r;
   assign cap_s.data  = cap_data_r;

   // A new sample landing while the old one still waits replaces it, so the old one is lost.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overrun_r <= 1'b0;
      end else if (tick_r && cap_valid_r && !cap_s.ready) begin
         overrun_r <= 1'b1;
      end else if (overrun_clr) begin
         overrun_r <= 1'b0;
      end
   end

   asm_sample_fifo #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_fifo (
      .clk   (core_clk),
      .rst_n (rst_n),
      .wr    (cap_s),
      .rd    (eng_s)
   );

   always_comb begin
      in_two   = 1'b1;
      in_span  = RING_WORDS;
      in_step  = 9'h002;
      in_idx_b = ring_add(in_wp_r, 9'h001, RING_WORDS);
      out_span = HALF_WORDS;
      out_step = 9'h001;
      case (mode_r)
         MODE_MONO: begin
            in_two   = 1'b0;
            in_step  = 9'h001;
            out_span = RING_WORDS;
         end
         MODE_SIMPLE: begin
            out_span = HALF_WORDS;
         end
         MODE_MIXED: begin
            in_span  = HALF_WORDS;
            in_step  = 9'h001;
            in_idx_b = in_wp_r + HALF_WORDS;
         end
         MODE_FULL: begin
            out_span = RING_WORDS;
            out_step = 9'h002;
         end
         default: begin
            in_two = 1'b1;
         end
      endcase
   end

   // A pending mode switch holds the buffer so no frame meets stale pointers.
   assign eng_s.ready = (state_r == ST_IDLE) && !fetch_pend_r &&
                        (mode_r == asm_mode_t'(audio_mode));
   assign mem_req     = (state_r != ST_IDLE);
   assign in_done     = mem_gnt && ((state_r == ST_WR_B) ||
                                    ((state_r == ST_WR_A) && !in_two));
   assign out_done    = mem_gnt && ((state_r == ST_RD_B) ||
                        ((state_r == ST_RD_A) && (mode_r != MODE_FULL)));

   // Mode only changes between accesses; pointers restart with it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= MODE_MONO;
      end else if (state_r == ST_IDLE) begin
         mode_r <= asm_mode_t'(audio_mode);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= ST_IDLE;
         frame_r     <= 32'h0000_0000;
         mem_we_r    <= 1'b0;
         mem_bank_r  <= 1'b0;
         mem_addr_r  <= 16'h0000;
         mem_wdata_r <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               // output prefetch wins so playback never starves.
               if (mode_r != asm_mode_t'(audio_mode)) begin
                  state_r <= ST_IDLE;
               end else if (fetch_pend_r) begin
                  state_r    <= ST_RD_A;
                  mem_we_r   <= 1'b0;
                  mem_bank_r <= 1'b1;
                  mem_addr_r <= ring_abs(OUT_RING_BASE, out_rp_r);
               end else if (eng_s.valid) begin
                  state_r     <= ST_WR_A;
                  frame_r     <= eng_s.data;
                  mem_we_r    <= 1'b1;
                  mem_bank_r  <= 1'b0;
                  mem_addr_r  <= ring_abs(IN_RING_BASE, in_wp_r);
                  mem_wdata_r <= eng_s.data[SMP_W-1:0];
               end
            end
            ST_WR_A: begin
               if (mem_gnt && in_two) begin
                  state_r     <= ST_WR_B;
                  mem_addr_r  <= ring_abs(IN_RING_BASE, in_idx_b);
                  mem_wdata_r <= frame_r[BUF_W-1:SMP_W];
               end else if (mem_gnt) begin
                  state_r  <= ST_IDLE;
                  mem_we_r <= 1'b0;
               end
            end
            ST_RD_A: begin
               if (mem_gnt && (mode_r == MODE_FULL)) begin
                  state_r    <= ST_RD_B;
                  mem_addr_r <= ring_abs(OUT_RING_BASE,
                                ring_add(out_rp_r, 9'h001, out_span));
               end else if (mem_gnt) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_WR_B, ST_RD_B: begin
               if (mem_gnt) begin
                  state_r  <= ST_IDLE;
                  mem_we_r <= 1'b0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // input write pointer and newest block.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_wp_r          <= 9'h000;
         in_blk_start_r   <= 9'h000;
         in_newest_r      <= 9'h000;
         in_blk_cnt_r     <= 9'h000;
         blk_full_pulse_r <= 1'b0;
      end else if (state_r == ST_IDLE &&
                   mode_r != asm_mode_t'(audio_mode)) begin
         in_wp_r          <= 9'h000;
         in_blk_start_r   <= 9'h000;
         in_blk_cnt_r     <= 9'h000;
         blk_full_pulse_r <= 1'b0;
      end else begin
         blk_full_pulse_r <= 1'b0;
         if (in_done) begin
            in_wp_r <= ring_add(in_wp_r, in_step, in_span);
            if (in_blk_cnt_r == BLOCK_LEN - 9'h001) begin
               in_blk_cnt_r     <= 9'h000;
               in_newest_r      <= in_blk_start_r;
               in_blk_start_r   <= ring_add(in_wp_r, in_step, in_span);
               blk_full_pulse_r <= 1'b1;
            end else begin
               in_blk_cnt_r <= in_blk_cnt_r + 9'h001;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_newest_addr_r <= 16'h0000;
      end else begin
         in_newest_addr_r <= ring_abs(IN_RING_BASE, in_newest_r);
      end
   end

   // output read pointer and block tracking.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_rp_r        <= 9'h000;
         out_blk_start_r <= 9'h000;
         out_blk_cnt_r   <= 9'h000;
      end else if (state_r == ST_IDLE &&
                   mode_r != asm_mode_t'(audio_mode)) begin
         out_rp_r        <= 9'h000;
         out_blk_start_r <= 9'h000;
         out_blk_cnt_r   <= 9'h000;
      end else if (out_done) begin
         out_rp_r <= ring_add(out_rp_r, out_step, out_span);
         if (out_blk_cnt_r == BLOCK_LEN - 9'h001) begin
            out_blk_cnt_r   <= 9'h000;
            out_blk_start_r <= ring_add(out_rp_r, out_step, out_span);
         end else begin
            out_blk_cnt_r <= out_blk_cnt_r + 9'h001;
         end
      end
   end

   // Prefetch request: a tick wins over the clear of the same cycle.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_pend_r <= 1'b0;
      end else if (tick_r) begin
         fetch_pend_r <= 1'b1;
      end else if (out_done) begin
         fetch_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         next_ch0_r <= 16'h0000;
         next_ch1_r <= 16'h0000;
      end else if (mem_gnt && state_r == ST_RD_A) begin
         next_ch0_r <= mem_rdata;
         next_ch1_r <= (mode_r == MODE_FULL) ? next_ch1_r : MUTE_LEVEL;
      end else if (mem_gnt && state_r == ST_RD_B) begin
         next_ch1_r <= mem_rdata;
      end
   end

   // output stage fed once per sample period.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_ch0_r <= 16'h0000;
         dac_ch1_r <= 16'h0000;
      end else if (tick_r) begin
         dac_ch0_r <= mute_r ? MUTE_LEVEL : next_ch0_r;
         dac_ch1_r <= mute_r ? MUTE_LEVEL : next_ch1_r;
      end
   end

   asm_view_map u_in_view (
      .clk    (core_clk),
      .rst_n  (rst_n),
      .base   (IN_RING_BASE),
      .anchor (in_newest_r),
      .span   (in_span),
      .ofs    (smart_in_ofs),
      .addr_r (smart_in_addr_r)
   );

   asm_view_map u_out_view (
      .clk    (core_clk),
      .rst_n  (rst_n),
      .base   (OUT_RING_BASE),
      .anchor (out_blk_start_r),
      .span   (out_span),
      .ofs    (smart_out_ofs),
      .addr_r (smart_out_addr_r)
   );
endmodule // asm_mover
`default_nettype wire

//--- testbench/asm_mover_props.sv
// Concurrent checks on the ports of the audio sample mover.
// Assumes one core clock; the raw reset input disables every check.
`timescale 1ns/1ps
`default_nettype none
module asm_mover_props import asm_pkg::*; (
   input wire logic             core_clk,
   input wire logic             arst_n,
   input wire logic             low_batt,
   input wire logic [1:0]       audio_mode,
   input wire logic [SMP_W-1:0] dac_ch0_r,
   input wire logic [SMP_W-1:0] dac_ch1_r,
   input wire logic             mute_r,
   input wire logic             mem_req,
   input wire logic             mem_gnt,
   input wire logic             mem_we_r,
   input wire logic             mem_bank_r,
   input wire logic [ADR_W-1:0] mem_addr_r,
   input wire logic [SMP_W-1:0] mem_wdata_r,
   input wire logic             blk_full_pulse_r,
   input wire logic             overrun_clr,
   input wire logic             overrun_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   req_hold_a: assert property (mem_req && !mem_gnt |=> mem_req
      && $stable({mem_we_r, mem_bank_r, mem_addr_r, mem_wdata_r}))
      else $error("memory request changed before grant");
   dir_bank_a: assert property (mem_req |-> mem_we_r != mem_bank_r)
      else $error("access direction and bank disagree");
   ring_range_a: assert property (mem_req |->
      mem_addr_r - IN_RING_BASE < {7'h00, RING_WORDS})
      else $error("access outside the ring");
   // Matching the mode of eight cycles back keeps a mode switch mid-frame out of the check.
   low_out_a: assert property (mem_req && !mem_we_r
      && audio_mode inside {MODE_SIMPLE, MODE_MIXED}
      && audio_mode == $past(audio_mode, 8)
      |-> mem_addr_r - OUT_RING_BASE < {7'h00, HALF_WORDS})
      else $error("single output read above lower half");
   pair_next_a: assert property (mem_req && $past(mem_req && mem_gnt)
      && (audio_mode == MODE_FULL || audio_mode == MODE_SIMPLE && mem_we_r)
      && audio_mode == $past(audio_mode, 8)
      |-> mem_addr_r == $past(mem_addr_r) + 16'h0001)
      else $error("second word of a frame not adjacent");
   pair_half_a: assert property (mem_req && $past(mem_req && mem_gnt)
      && audio_mode == MODE_MIXED && mem_we_r
      && audio_mode == $past(audio_mode, 8)
      |-> mem_addr_r == $past(mem_addr_r) + {7'h00, HALF_WORDS})
      else $error("second channel not in the upper half");
   mono_gap_a: assert property (mem_req && mem_gnt
      && audio_mode == MODE_MONO && audio_mode == $past(audio_mode, 8)
      |=> !mem_req) else $error("mono frame longer than one word");
   pulse_once_a: assert property (blk_full_pulse_r
      |=> !blk_full_pulse_r [*8]) else $error("block pulse too long");
   mute_on_a: assert property (low_batt [*8] |-> mute_r)
      else $error("no mute under low battery");
   mute_off_a: assert property (!low_batt [*8] |-> !mute_r)
      else $error("mute without low battery");
   mute_dac_a: assert property (mute_r && $past(mute_r)
      && $changed({dac_ch0_r, dac_ch1_r})
      |-> {dac_ch0_r, dac_ch1_r} == {MUTE_LEVEL, MUTE_LEVEL})
      else $error("output not silent while muted");
   clr_fall_a: assert property ($fell(overrun_r) |-> $past(overrun_clr))
      else $error("overrun flag dropped without a clear");
endmodule // asm_mover_props

bind asm_mover asm_mover_props u_props (.core_clk, .arst_n, .low_batt,
   .audio_mode, .dac_ch0_r, .dac_ch1_r, .mute_r, .mem_req, .mem_gnt,
   .mem_we_r, .mem_bank_r, .mem_addr_r, .mem_wdata_r, .blk_full_pulse_r,
   .overrun_clr, .overrun_r);
`default_nettype wire

//--- testbench/asm_ram_model.sv
// Behavioural shared RAM on the far side of the mover's memory port.
// Assumes requests hold until granted; lag sets the wait before a grant.
`timescale 1ns/1ps
`default_nettype none
module asm_ram_model import asm_pkg::*; (
   input  wire logic             core_clk,
   input  wire logic [11:0]      lag,
   input  wire logic             mem_req,
   input  wire logic             mem_we_r,
   input  wire logic             mem_bank_r,
   input  wire logic [ADR_W-1:0] mem_addr_r,
   input  wire logic [SMP_W-1:0] mem_wdata_r,
   output logic                  mem_gnt,
   output logic      [SMP_W-1:0] mem_rdata
);
   logic [SMP_W-1:0] ram [0:1][0:511];
   logic [11:0]      wait_r;

   initial begin
      mem_gnt = 1'b0;
      mem_rdata = 16'h0000;
      wait_r = 12'h000;
   end
   // shared ring store
   // Read data toggles when not granted, so a stale value never passes.
   always @(posedge core_clk) begin
      if (mem_req && mem_gnt && mem_we_r) begin
         ram[mem_bank_r][mem_addr_r[8:0]] <= mem_wdata_r;
      end
      if (mem_req && !mem_gnt && wait_r >= lag) begin
         mem_gnt <= 1'b1;
         mem_rdata <= ram[mem_bank_r][mem_addr_r[8:0]];
         wait_r <= 12'h000;
      end else begin
         mem_gnt <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_r <= (mem_req && !mem_gnt) ? wait_r + 12'h001 : 12'h000;
      end
   end
endmodule // asm_ram_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the audio sample mover.
// Assumes the RAM model answers the memory port; converter clock runs free.
`timescale 1ns/1ps
`default_nettype none
module tb import asm_pkg::*; ;
   localparam int TICK = 256;
   logic             core_clk, arst_n, conv_clk, low_batt, mute_r;
   logic             mem_req, mem_we_r, mem_bank_r, mem_gnt;
   logic             blk_full_pulse_r, overrun_clr, overrun_r;
   logic [1:0]       audio_mode, conv_div;
   logic [11:0]      lag;
   logic [SMP_W-1:0] adc_ch0, adc_ch1, dac_ch0_r, dac_ch1_r;
   logic [SMP_W-1:0] mem_wdata_r, mem_rdata;
   logic [ADR_W-1:0] mem_addr_r, smart_in_addr_r, smart_out_addr_r;
   logic [ADR_W-1:0] in_newest_addr_r;
   logic [IDX_W-1:0] smart_in_ofs, smart_out_ofs;
   int               error_cnt, checked, cyc;

   asm_mover uut (.core_clk, .arst_n, .conv_clk, .low_batt, .audio_mode,
      .adc_ch0, .adc_ch1, .dac_ch0_r, .dac_ch1_r, .mute_r, .mem_req,
      .mem_we_r, .mem_bank_r, .mem_addr_r, .mem_wdata_r, .mem_gnt,
      .mem_rdata, .smart_in_ofs, .smart_in_addr_r, .smart_out_ofs,
      .smart_out_addr_r, .in_newest_addr_r, .blk_full_pulse_r,
      .overrun_clr, .overrun_r);
   asm_ram_model ram_m (.core_clk, .lag, .mem_req, .mem_we_r, .mem_bank_r,
      .mem_addr_r, .mem_wdata_r, .mem_gnt, .mem_rdata);

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Converter clock at a quarter of the core rate: one tick per 256 cycles.
   always @(negedge core_clk) begin
      conv_div <= conv_div + 2'h1;
      conv_clk <= conv_div[1];
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt = error_cnt + 1;
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wait_pulse();
      int i;
      for (i = 0; i < 40 * TICK && blk_full_pulse_r !== 1'b1; i++) begin
         @(negedge core_clk);
      end
      check({15'h0000, blk_full_pulse_r}, 16'h0001);
      @(negedge core_clk);
   endtask
   task automatic wait_dac();
      logic [15:0] old;
      int          i;
      old = dac_ch0_r;
      for (i = 0; i < 2 * TICK && dac_ch0_r === old; i++) begin
         @(negedge core_clk);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic t_mono();
      logic [15:0] a;
      int          i;
      wait_pulse();
      check(in_newest_addr_r, IN_RING_BASE);
      for (i = 0; i < 32; i++) begin
         check(ram_m.ram[0][i], adc_ch0);
      end
      smart_in_ofs = 9'h020;
      cycles(2);
      check(smart_in_addr_r, 16'h1820);
      wait_pulse();
      check(in_newest_addr_r, 16'h1820);
      cycles(2);
      check(smart_in_addr_r, 16'h1840);
      check(smart_out_addr_r, 16'h1840);
      smart_in_ofs = 9'h170;
      cycles(2);
      check(smart_in_addr_r, 16'h1810);
      wait_dac();
      a = dac_ch0_r;
      cycles(TICK - 1);
      check(dac_ch0_r, a);
      cycles(1);
      check(dac_ch0_r, a + 16'h0001);
      check(dac_ch1_r, 16'h0000);
   endtask

   task automatic t_layouts();
      int          m;
      logic [15:0] c0;
      for (m = 1; m < 4; m++) begin
         c0 = {m[3:0], 12'hA5A};
         adc_ch0 = c0;
         adc_ch1 = ~c0;
         cycles(2 * TICK);
         audio_mode = m[1:0];
         cycles(6 * TICK);
         if (m == 2) begin
            check(ram_m.ram[0][1], c0);
            check(ram_m.ram[0][193], ~c0);
         end else begin
            check(ram_m.ram[0][2], c0);
            check(ram_m.ram[0][3], ~c0);
         end
         if (m == 3) begin
            check(dac_ch1_r, dac_ch0_r + 16'h0001);
         end else begin
            check(dac_ch1_r, 16'h0000);
            check({15'h0000, dac_ch0_r < 16'h40C0}, 16'h0001);
         end
      end
   endtask

   task automatic t_mute();
      low_batt = 1'b1;
      cycles(10);
      check({15'h0000, mute_r}, 16'h0001);
      cycles(2 * TICK);
      check(dac_ch0_r | dac_ch1_r, MUTE_LEVEL);
      low_batt = 1'b0;
      cycles(10);
      check({15'h0000, mute_r}, 16'h0000);
      cycles(2 * TICK);
      check(dac_ch1_r, dac_ch0_r + 16'h0001);
   endtask

   // A stalled RAM fills the buffer until frames are refused.
   task automatic t_overrun();
      int i;
      adc_ch0 = 16'h7E57;
      audio_mode = MODE_MONO;
      cycles(10);
      lag = 12'h5DC;
      for (i = 0; i < 80 * TICK && overrun_r !== 1'b1; i++) begin
         @(negedge core_clk);
      end
      check({15'h0000, overrun_r}, 16'h0001);
      lag = 12'h000;
      cycles(10 * TICK);
      check({15'h0000, overrun_r}, 16'h0001);
      check(ram_m.ram[0][5], 16'h7E57);
      overrun_clr = 1'b1;
      cycles(1);
      overrun_clr = 1'b0;
      cycles(4 * TICK);
      check({15'h0000, overrun_r}, 16'h0000);
   endtask

   initial begin
      int i;
      arst_n = 1'b0;
      conv_div = 2'h0;
      conv_clk = 1'b0;
      low_batt = 1'b0;
      audio_mode = MODE_MONO;
      adc_ch0 = 16'h1234;
      adc_ch1 = 16'hBEEF;
      lag = 12'h000;
      smart_in_ofs = 9'h000;
      smart_out_ofs = 9'h000;
      overrun_clr = 1'b0;
      error_cnt = 0;
      checked = 0;
      cyc = 0;
      for (i = 0; i < 384; i++) begin
         ram_m.ram[1][i] = 16'h4000 + i[15:0];
      end
      cycles(20);
      arst_n = 1'b1;
      t_mono();
      t_layouts();
      t_mute();
      t_overrun();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
